//--- standard_pwm_timebase_unit.sv
// Standard PWM channel with three selectable period timers
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module standard_pwm_timebase_unit (
  input wire logic clk_sys, // System clock, 50 MHz
  input wire logic srst, // Synchronous reset, active high
  input wire logic sleep_req, // High while the device sleeps
  input wire logic [5:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, cycle after the strobe
  output logic modulated_output_pin, // Pin output level
  output logic modulated_output_pin_oe // Pin output enable
);

  localparam int NT = pwm_timebase_pkg::NUM_TIMERS;

  logic [7:0] channel_control_reg;
  logic [7:0] duty_upper_write_reg;
  logic [7:0] duty_active_buffer_reg;
  logic [1:0] duty_low_latch_reg;
  logic [1:0] timebase_select_field;
  logic [NT-1:0] timer_match_flag;
  logic pin_direction_bit;
  logic [7:0] period_limit_reg [NT];
  pwm_timebase_pkg::timer_ctrl_t timer_control_reg [NT];
  logic [7:0] rdata_reg;
  logic pin_reg;
  logic pin_oe_reg;

  logic [7:0] period_timer_count [NT];
  logic [1:0] timer_fine [NT];
  logic [NT-1:0] timer_wrap;
  logic [NT-1:0] cnt_wr;
  logic wr_ok;
  logic pwm_on;
  logic sel_wrap;
  logic [9:0] time_base;
  pwm_timebase_pkg::duty_t duty_written;
  pwm_timebase_pkg::duty_t duty_active;
  logic wrap_seen_reg;
  logic ctl_we;
  logic duty_we;
  logic buf_we;
  logic sel_we;
  logic flag_we;
  logic dir_we;
  logic [NT-1:0] lim_we;
  logic [NT-1:0] tctl_we;
  logic [7:0] rd_value;

  function automatic logic hit(input logic [5:0] addr, input int idx,
                               input logic [5:0] ofs);
    logic [5:0] base;
    base = pwm_timebase_pkg::OFS_TIMER_BASE +
           6'(idx) * pwm_timebase_pkg::OFS_TIMER_STRIDE;
    hit = (addr == base + ofs);
  endfunction : hit

  // One register strobe; a write in sleep never reaches any register
  function automatic logic wr_at(input logic en, input logic [5:0] addr,
                                 input logic [5:0] ofs);
    wr_at = en && (addr == ofs);
  endfunction : wr_at

  // Sleep freezes software writes too, so only the read data move while asleep
  assign wr_ok = reg_wr && !sleep_req;
  assign pwm_on = pwm_timebase_pkg::pwm_mode(channel_control_reg);

  ////////////////////////////////////////////////////////////////////////
  // Write decode of the channel registers

  assign ctl_we = wr_at(wr_ok, reg_addr,
                        pwm_timebase_pkg::OFS_CHANNEL_CONTROL);
  assign duty_we = wr_at(wr_ok, reg_addr,
                         pwm_timebase_pkg::OFS_DUTY_UPPER_WRITE);
  assign buf_we = wr_at(wr_ok, reg_addr,
                        pwm_timebase_pkg::OFS_DUTY_ACTIVE_BUFFER);
  assign sel_we = wr_at(wr_ok, reg_addr,
                        pwm_timebase_pkg::OFS_TIMEBASE_SELECT);
  assign flag_we = wr_at(wr_ok, reg_addr,
                         pwm_timebase_pkg::OFS_PERIPHERAL_FLAG);
  assign dir_we = wr_at(wr_ok, reg_addr,
                        pwm_timebase_pkg::OFS_PIN_DIRECTION);

  ////////////////////////////////////////////////////////////////////////
  // Timers

  generate
    for (genvar i = 0; i < NT; i++)
    begin : g_timer
      assign cnt_wr[i] = wr_ok &&
                         hit(reg_addr, i, pwm_timebase_pkg::OFS_TIMER_COUNT);

      period_timer u_timer (
        .clk_sys(clk_sys),
        .srst(srst),
        .ctrl(timer_control_reg[i]),
        .limit(period_limit_reg[i]),
        .freeze(sleep_req),
        .cnt_wr(cnt_wr[i]),
        .cnt_wdata(reg_wdata),
        .count(period_timer_count[i]),
        .fine(timer_fine[i]),
        .wrap(timer_wrap[i])
      );

      assign lim_we[i] =
        wr_ok && hit(reg_addr, i, pwm_timebase_pkg::OFS_TIMER_LIMIT);
      assign tctl_we[i] =
        wr_ok && hit(reg_addr, i, pwm_timebase_pkg::OFS_TIMER_CONTROL);

      always_ff @(posedge clk_sys)
      begin
        if (srst)
          period_limit_reg[i] <= pwm_timebase_pkg::RST_LIMIT;
        else if (lim_we[i])
          period_limit_reg[i] <= reg_wdata;
      end

      always_ff @(posedge clk_sys)
      begin
        if (srst)
          timer_control_reg[i] <= pwm_timebase_pkg::RST_BYTE;
        else if (tctl_we[i])
          timer_control_reg[i] <= {1'b0, reg_wdata[6:0]};
      end

      // Set beats a same-cycle clear
      always_ff @(posedge clk_sys)
      begin
        if (srst)
          timer_match_flag[i] <= 1'b0;
        else if (timer_wrap[i])
          timer_match_flag[i] <= 1'b1;
        else if (flag_we && !reg_wdata[i])
          timer_match_flag[i] <= 1'b0;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Time base selection; code 3 selects no timer

  always_comb
  begin
    sel_wrap = 1'b0;
    time_base = 10'h000;
    for (int i = 0; i < NT; i++)
    begin
      if (timebase_select_field == 2'(i))
      begin
        sel_wrap = timer_wrap[i];
        time_base = {period_timer_count[i], timer_fine[i]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel registers

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      channel_control_reg <= pwm_timebase_pkg::RST_CHANNEL_CONTROL;
    else if (ctl_we)
      channel_control_reg <= reg_wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      duty_upper_write_reg <= pwm_timebase_pkg::RST_BYTE;
    else if (duty_we)
      duty_upper_write_reg <= reg_wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      timebase_select_field <= 2'h0;
    else if (sel_we)
      timebase_select_field <= reg_wdata[1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pin_direction_bit <= pwm_timebase_pkg::RST_PIN_DIRECTION;
    else if (dir_we)
      pin_direction_bit <= reg_wdata[0];
  end

  assign duty_written.upper = duty_upper_write_reg;
  assign duty_written.low =
    channel_control_reg[pwm_timebase_pkg::CTL_DUTY_LOW_LSB +: 2];
  assign duty_active.upper = duty_active_buffer_reg;
  assign duty_active.low = duty_low_latch_reg;

  ////////////////////////////////////////////////////////////////////////
  // Double buffer: both parts load at the period boundary in pwm mode; outside pwm mode software writes the buffer

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      duty_active_buffer_reg <= pwm_timebase_pkg::RST_BYTE;
      duty_low_latch_reg <= 2'h0;
    end
    else if (pwm_on && sel_wrap)
    begin
      duty_active_buffer_reg <= duty_written.upper;
      duty_low_latch_reg <= duty_written.low;
    end
    else if (!pwm_on && buf_we)
      duty_active_buffer_reg <= reg_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin: set at boundary, cleared on duty match; held while asleep

  // The pin is set one clock after the wrap, once the buffer holds the
  // new duty; the compare also lags one clock, so the high time is exact
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wrap_seen_reg <= 1'b0;
    else if (!sleep_req)
      wrap_seen_reg <= pwm_on && sel_wrap;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pin_reg <= 1'b0;
    else if (sleep_req)
      pin_reg <= pin_reg;
    else if (!pwm_on)
      pin_reg <= 1'b0;
    else if (wrap_seen_reg)
      pin_reg <= (duty_active != 10'h000);
    else if (time_base == duty_active)
      pin_reg <= 1'b0;
  end

  // A zero control register leaves pwm mode and hands the pin back
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pin_oe_reg <= 1'b0;
    else if (!sleep_req)
      pin_oe_reg <= pwm_on && !pin_direction_bit;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: data stand one cycle after the strobe, else zero

  always_comb
  begin
    rd_value = 8'h00;
    case (reg_addr)
      pwm_timebase_pkg::OFS_CHANNEL_CONTROL:
        rd_value = channel_control_reg;
      pwm_timebase_pkg::OFS_DUTY_UPPER_WRITE:
        rd_value = duty_upper_write_reg;
      pwm_timebase_pkg::OFS_DUTY_ACTIVE_BUFFER:
        rd_value = duty_active_buffer_reg;
      pwm_timebase_pkg::OFS_TIMEBASE_SELECT:
        rd_value = {6'h00, timebase_select_field};
      pwm_timebase_pkg::OFS_PERIPHERAL_FLAG:
        rd_value = {5'h00, timer_match_flag};
      pwm_timebase_pkg::OFS_PIN_DIRECTION:
        rd_value = {7'h00, pin_direction_bit};
      default:
      begin
        for (int i = 0; i < NT; i++)
        begin
          if (hit(reg_addr, i, pwm_timebase_pkg::OFS_TIMER_COUNT))
            rd_value = period_timer_count[i];
          if (hit(reg_addr, i, pwm_timebase_pkg::OFS_TIMER_LIMIT))
            rd_value = period_limit_reg[i];
          if (hit(reg_addr, i, pwm_timebase_pkg::OFS_TIMER_CONTROL))
            rd_value = timer_control_reg[i];
        end
      end
    endcase
  end

  // Registered so the data stand exactly one cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (srst || !reg_rd)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rd_value;
  end

  assign reg_rdata = rdata_reg;
  assign modulated_output_pin = pin_reg;
  assign modulated_output_pin_oe = pin_oe_reg;

endmodule : standard_pwm_timebase_unit
`default_nettype wire

//--- pwm_timebase_pkg.sv
// Package: register map, field layout and types of the PWM time base unit
//
// Contract
// - Period equals (limit+1) x 4 x prescale clocks
// - Past limit match: clear timer, set pin
// - Zero duty never sets pin at boundary
// - Boundary copies upper duty into buffer register
// - Postscaler never affects output frequency
// - Duty is upper byte plus control bits 5:4
// - Duty writes anytime, applied at next boundary; the code drops duty writes made while sleep_req is high
// - Buffer register read-only in modulation mode
// - High time equals duty x prescale clocks
// - Buffer and hidden 2-bit latch load together
// - Time base: timer plus phase/prescaler bits
// - Pin cleared when time base equals duty
// - Duty beyond period keeps pin high
// - Select field picks one of three timers
// - Eight-bit timer and limit set the period
// - Prescale ratios 1, 4 and 16
// - Resolution log2(4(limit+1)), ten bits maximum
// - Sleep freezes timer, state and pin level
// - Wake resumes from held timer value
// - Zero control register releases the pin
// - Reset restores defaults, pin becomes input
package pwm_timebase_pkg;

  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int NUM_TIMERS = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CHANNEL_CONTROL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_DUTY_UPPER_WRITE = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_DUTY_ACTIVE_BUFFER = 6'h02;
  localparam logic [ADDR_W-1:0] OFS_TIMEBASE_SELECT = 6'h03;
  localparam logic [ADDR_W-1:0] OFS_PERIPHERAL_FLAG = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_PIN_DIRECTION = 6'h05;
  // Timer n: base + n x stride, then count, limit and control
  localparam logic [ADDR_W-1:0] OFS_TIMER_BASE = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_TIMER_STRIDE = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_TIMER_COUNT = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMER_LIMIT = 6'h01;
  localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL = 6'h02;

  // Channel control fields
  localparam int CTL_DUTY_LOW_LSB = 4;
  localparam int CTL_MODE_LSB = 0;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // Reset values
  localparam logic [DATA_W-1:0] RST_CHANNEL_CONTROL = 8'h00;
  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] RST_LIMIT = 8'hFF;
  localparam logic RST_PIN_DIRECTION = 1'h1;

  // Timer prescale encodings
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV4 = 2'h1;
  localparam logic [5:0] PS_LAST_DIV1 = 6'h03;
  localparam logic [5:0] PS_LAST_DIV4 = 6'h0F;
  localparam logic [5:0] PS_LAST_DIV16 = 6'h3F;

  typedef struct packed {
    logic reserved;
    logic [3:0] postscale;
    logic run;
    logic [1:0] prescale;
  } timer_ctrl_t;

  typedef struct packed {
    logic [7:0] upper;
    logic [1:0] low;
  } duty_t;

  // Last prescaler count of one timer step: 4 clocks times the ratio
  function automatic logic [5:0] prescale_last(input logic [1:0] ps);
    case (ps)
      PS_DIV1: prescale_last = PS_LAST_DIV1;
      PS_DIV4: prescale_last = PS_LAST_DIV4;
      default: prescale_last = PS_LAST_DIV16;
    endcase
  endfunction : prescale_last

  // Two fine time base bits: clock phase at 1:1, else prescaler top bits
  function automatic logic [1:0] fine_bits(input logic [5:0] cnt,
                                           input logic [1:0] ps);
    case (ps)
      PS_DIV1: fine_bits = cnt[1:0];
      PS_DIV4: fine_bits = cnt[3:2];
      default: fine_bits = cnt[5:4];
    endcase
  endfunction : fine_bits

  function automatic logic pwm_mode(input logic [DATA_W-1:0] ctl);
    pwm_mode = (ctl[CTL_MODE_LSB+3 -: 2] == MODE_PWM_TOP);
  endfunction : pwm_mode

endpackage : pwm_timebase_pkg

//--- period_timer.sv
// Eight-bit period timer with prescaler producing a ten-bit time base
`timescale 1ns/1ps
`default_nettype none
module period_timer (
  input wire logic clk_sys, // System clock
  input wire logic srst, // Synchronous reset, active high
  input wire pwm_timebase_pkg::timer_ctrl_t ctrl, // Run and prescale
  input wire logic [7:0] limit, // Period limit value
  input wire logic freeze, // Sleep: hold all state
  input wire logic cnt_wr, // Software write of the count
  input wire logic [7:0] cnt_wdata, // Count write data
  output logic [7:0] count, // Timer count
  output logic [1:0] fine, // Two low time base bits
  output logic wrap // Match-and-clear pulse
);

  logic [5:0] ps_reg;
  logic [7:0] count_reg;
  logic tick;

  ////////////////////////////////////////////////////////////////////////
  // Prescaler: postscale field is never looked at here

  assign tick = ctrl.run && !freeze &&
                (ps_reg == pwm_timebase_pkg::prescale_last(ctrl.prescale));

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ps_reg <= 6'h00;
    else if (cnt_wr)
      ps_reg <= 6'h00;
    else if (tick)
      ps_reg <= 6'h00;
    else if (ctrl.run && !freeze)
      ps_reg <= ps_reg + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////
  // Count: wraps on the step after equal to limit

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      count_reg <= 8'h00;
    else if (cnt_wr)
      count_reg <= cnt_wdata;
    else if (tick)
    begin
      if (count_reg == limit)
        count_reg <= 8'h00;
      else
        count_reg <= count_reg + 8'h01;
    end
  end

  assign wrap = tick && (count_reg == limit);
  assign count = count_reg;
  assign fine = pwm_timebase_pkg::fine_bits(ps_reg, ctrl.prescale);

endmodule : period_timer
`default_nettype wire

//--- pwm_unit_sva.sv
// Port assertions for the PWM time base unit
`timescale 1ns/1ps
`default_nettype none
module pwm_unit_chk (
  input wire logic clk_sys, // Clock
  input wire logic srst, // Reset
  input wire logic sleep_req, // Sleep
  input wire logic [5:0] reg_addr, // Address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic modulated_output_pin, // Pin level
  input wire logic modulated_output_pin_oe // Pin enable
);
  logic pwm_reg;
  logic dir_reg;
  wire logic pin = modulated_output_pin;
  wire logic oe = modulated_output_pin_oe;
  wire logic en = pwm_reg && !dir_reg;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Shadows of mode and direction; sleep blocks writes
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pwm_reg <= 1'b0;
    else if (reg_wr && !sleep_req && reg_addr == 6'h00)
      pwm_reg <= reg_wdata[3:2] == 2'h3;
  end
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      dir_reg <= 1'b1;
    else if (reg_wr && !sleep_req && reg_addr == 6'h05)
      dir_reg <= reg_wdata[0];
  end
  sequence s_sleep2;
    sleep_req ##1 sleep_req;
  endsequence
  sequence s_ctl_clear;
    reg_wr && !sleep_req && reg_addr == 6'h00 && reg_wdata == 8'h00;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_quiet: assert property
    ($fell(srst) |-> !pin && !oe && reg_rdata == 8'h00)
    else $error("pin or data active after reset");
  chk_sleep_pin: assert property (sleep_req |=> $stable(pin))
    else $error("pin moved in sleep");
  chk_sleep_oe: assert property
    (s_sleep2 |=> oe == $past(oe, 2))
    else $error("enable moved in sleep");
  chk_zero_release: assert property
    (s_ctl_clear |-> ##2 !oe && !pin)
    else $error("pin kept after control cleared");
  chk_oe_follows: assert property (oe == $past(en))
    else $error("enable not mode and direction");
  chk_pin_off_mode: assert property
    (!pwm_reg && !sleep_req |=> !pin)
    else $error("pin high outside modulation");
  chk_rise_gap: assert property
    ($rose(pin) |=> !$rose(pin) [*3])
    else $error("period shorter than four clocks");
  chk_read_idle: assert property
    (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read window");
endmodule : pwm_unit_chk
bind standard_pwm_timebase_unit pwm_unit_chk pwm_unit_chk_i (
  .clk_sys(clk_sys), .srst(srst), .sleep_req(sleep_req),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .modulated_output_pin(modulated_output_pin),
  .modulated_output_pin_oe(modulated_output_pin_oe));
`default_nettype wire

//--- pwm_load_model.sv
// Load on the pin: measures high time, period and rises
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
  input wire logic clk_sys, // Clock
  input wire logic srst, // Clears the counts
  input wire logic pin, // Driven level
  input wire logic oe, // Driver on
  output logic lvl, // Level at the load
  output logic [15:0] hi, // Last high time
  output logic [15:0] per, // Last rise-to-rise time
  output logic [15:0] rises // Rising edges seen
);
  logic lvl_q;
  logic [15:0] hc;
  logic [15:0] pc;
  // Pull-down holds the line low once the driver lets go
  assign lvl = oe ? pin : 1'b0;
  always_ff @(posedge clk_sys)
  begin
    lvl_q <= lvl;
    if (srst)
    begin
      rises <= 16'h0000;
      hc <= 16'h0000;
      pc <= 16'h0000;
    end
    else if (lvl && !lvl_q)
    begin
      per <= pc;
      pc <= 16'h0001;
      hc <= 16'h0001;
      rises <= rises + 16'h0001;
    end
    else
    begin
      pc <= pc + 16'h0001;
      hc <= hc + {15'h0000, lvl};
    end
    if (!lvl && lvl_q)
      hi <= hc;
  end
endmodule : pwm_load_model
`default_nettype wire

//--- standard_pwm_timebase_unit_bench.sv
// Register-level tests of the PWM time base unit
`timescale 1ns/1ps
`default_nettype none
module standard_pwm_timebase_unit_bench;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic sleep_req = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pin;
  logic oe;
  logic lvl;
  logic [15:0] hi;
  logic [15:0] per;
  logic [15:0] rises;
  logic [15:0] n;
  logic [7:0] d;
  int miscompares = 0;
  int total_checks = 0;
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  standard_pwm_timebase_unit standard_pwm_timebase_unit_i (
    .clk_sys(clk_sys), .srst(srst), .sleep_req(sleep_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .modulated_output_pin(pin), .modulated_output_pin_oe(oe));
  pwm_load_model pwm_load_model_i (.clk_sys(clk_sys), .srst(srst),
    .pin(pin), .oe(oe), .lvl(lvl), .hi(hi), .per(per), .rises(rises));
  ////////////////////////////////////////////////////////////////////////////
  task automatic idle(input int c);
    repeat (c) @(posedge clk_sys);
  endtask : idle
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk({8'h00, v}, {8'h00, e});
  endtask : rc
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rc(6'h00, 8'h00);
    rc(6'h05, 8'h01);
    rc(6'h09, 8'hFF);
    rc(6'h3F, 8'h00);
    $display("test reset done");
    wr(6'h05, 8'h01);
    wr(6'h09, 8'h03);
    wr(6'h00, 8'h2C);
    wr(6'h01, 8'h02);
    wr(6'h03, 8'h00);
    wr(6'h04, 8'h00);
    wr(6'h0A, 8'h04);
    d = 8'h00;
    for (int i = 0; i < 40 && d[0] !== 1'b1; i++)
      rd(6'h04, d);
    chk({15'h0000, d[0]}, 16'h0001);
    wr(6'h05, 8'h00);
    idle(40);
    chk(hi, 16'h000A);
    chk(per, 16'h0010);
    rc(6'h02, 8'h02);
    wr(6'h02, 8'h55);
    rc(6'h02, 8'h02);
    $display("test setup done");
    // Postscale bits set on purpose: they must not stretch the period
    for (int p = 0; p < 3; p++)
    begin
      wr(6'h0A, 8'h7C | 8'(p));
      idle(64 << (2 * p));
      chk(per, 16'(16 << (2 * p)));
      chk(hi, 16'(10 << (2 * p)));
    end
    wr(6'h0A, 8'h04);
    @(posedge lvl);
    wr(6'h01, 8'h01);
    rc(6'h02, 8'h02);
    idle(40);
    rc(6'h02, 8'h01);
    chk(hi, 16'h0006);
    wr(6'h00, 8'h1C);
    idle(40);
    chk(hi, 16'h0005);
    $display("test duty done");
    wr(6'h01, 8'h00);
    wr(6'h00, 8'h0C);
    idle(40);
    n = rises;
    idle(40);
    chk(rises, n);
    wr(6'h01, 8'h10);
    idle(40);
    n = rises;
    idle(40);
    chk({15'h0000, lvl}, 16'h0001);
    chk(rises, n);
    $display("test limits done");
    wr(6'h0D, 8'h07);
    wr(6'h0E, 8'h04);
    wr(6'h01, 8'h02);
    wr(6'h00, 8'h2C);
    wr(6'h03, 8'h01);
    wr(6'h04, 8'h00);
    idle(100);
    chk(per, 16'h0020);
    chk(hi, 16'h000A);
    rc(6'h04, 8'h03);
    @(posedge clk_sys);
    sleep_req <= 1'b1;
    rd(6'h0C, d);
    idle(10);
    rc(6'h0C, d);
    wr(6'h0D, 8'h00);
    rc(6'h0D, 8'h07);
    @(posedge clk_sys);
    sleep_req <= 1'b0;
    idle(100);
    chk(per, 16'h0020);
    $display("test select and sleep done");
    wr(6'h00, 8'h00);
    idle(3);
    chk({14'h0000, pin, oe}, 16'h0000);
    @(posedge clk_sys);
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    rc(6'h0D, 8'hFF);
    rc(6'h05, 8'h01);
    $display("test release and reset done");
    report_and_stop();
  end
endmodule : standard_pwm_timebase_unit_bench
`default_nettype wire
